// ===== core/pin_drive_pkg.sv
/*
 * Constants, register offsets and carrier structs for the port pin drive
 * and repeater block.
 * Assumes a host register window with byte offsets and 8-bit data.
 */
// What this block does
// RL1: Port A buffers host data both ways, steered by read/write strobes in window.
// RL2: Repeater window is the OR of both peripheral-select decode terms.
// RL3: Configurer qualifies peripheral-select decode with program-store strobe high.
// RL4: Firmware sets repeater enable, bit 7 of memory-mapping control, first.
// RL5: Choosing repeater mode on one port A pin moves all eight pins.
// RL6: Repeater acts whenever the presented address lies inside the window.
// RL7: Port A in repeater mode serves no other function.
// RL8: Four port C scan-test pins are unusable; their register bits are absent.
// RL9: Drive-select registers reset to zero: push-pull, normal slew.
// RL10: Open-drain bit set makes the pin drive low only, release for high.
// RL11: Slew bit set gives fast slew; clear gives standard slew.
// RL12: Port A drive-select: open-drain bits 7..4, slew bits 3..0.
// RL13: Port B drive-select uses the same layout as port A.
// RL14: Port C drive-select implements open-drain bits 7, 4, 3, 2 only.
// RL15: Port D drive-select implements slew bits 2 and 1 only.
// RL16: Final enable combines array term, direction bit and, on port A, repeater.
// RL17: Enable readback returns the final output enable; one means driving.
// RL18: Port A and B enable readback at their offsets, bit n is pin n.
// RL19: Port C and D enable readback report implemented pins only.
// RL20: Pin enable is array enable term OR direction bit.
// RL21: Readback writes ignored; unimplemented bits read zero.
package pin_drive_pkg;

    localparam logic [7:0] OFF_A_DRIVE  = 8'h08;
    localparam logic [7:0] OFF_B_DRIVE  = 8'h09;
    localparam logic [7:0] OFF_A_OESTAT = 8'h0C;
    localparam logic [7:0] OFF_B_OESTAT = 8'h0D;
    localparam logic [7:0] OFF_C_DRIVE  = 8'h16;
    localparam logic [7:0] OFF_D_DRIVE  = 8'h17;
    localparam logic [7:0] OFF_C_OESTAT = 8'h1A;
    localparam logic [7:0] OFF_D_OESTAT = 8'h1B;

    localparam logic [7:0] DRIVE_RESET  = 8'h00;
    localparam logic [7:0] MASK_A       = 8'hFF;
    localparam logic [7:0] MASK_B       = 8'hFF;
    localparam logic [7:0] MASK_C       = 8'h9C;
    localparam logic [7:0] MASK_D       = 8'h06;
    // Open-drain capable positions per port; the rest of the mask is slew
    localparam logic [7:0] OD_A         = 8'hF0;
    localparam logic [7:0] OD_B         = 8'hF0;
    localparam logic [7:0] OD_C         = 8'h9C;
    localparam logic [7:0] OD_D         = 8'h00;
    localparam int         REPEAT_BIT   = 7;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
    } port_byte_s;

endpackage : pin_drive_pkg

// ===== core/pin_drive.sv
/*
 * Port pin output stage: drive-type registers, final output enables,
 * enable readback and the port A data bus repeater.
 * Assumes the host strobes, select decode and array terms are already
 * synchronous to CLK; register accesses are single-cycle strobes.
 * Port A pin levels come from outside and pass two flops, so repeater
 * read data reaches the host three edges after the read cycle.
 */
`timescale 1ns/100ps
module pin_drive (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RESET_N,
    // Host register window
    input  wire logic                     REG_WR,
    input  wire logic                     REG_RD,
    input  wire logic [7:0]               REG_ADDR,
    input  wire logic [7:0]               REG_WDATA,
    output logic      [7:0]               REG_RDATA,
    // Repeater control from the host side
    input  wire logic [7:0]               MEMORY_MAPPING_CONTROL,
    input  wire logic                     REPEATER_MODE_SEL,
    input  wire logic                     PERIPH_SELECT_ZERO,
    input  wire logic                     PERIPH_SELECT_ONE,
    input  wire logic                     HOST_RD_N,
    input  wire logic                     HOST_WR_N,
    input  wire logic [7:0]               HOST_DATA_OUT,
    output logic      [7:0]               HOST_DATA_IN,
    output logic                          HOST_DATA_IN_VALID,
    // Per-pin sources
    input  wire pin_drive_pkg::port_byte_s ARRAY_OE,
    input  wire pin_drive_pkg::port_byte_s DIRECTION,
    input  wire pin_drive_pkg::port_byte_s PIN_DATA,
    // Pins
    input  wire pin_drive_pkg::port_byte_s PIN_IN,
    output pin_drive_pkg::port_byte_s     PIN_OUT,
    output pin_drive_pkg::port_byte_s     PIN_OE,
    output pin_drive_pkg::port_byte_s     PIN_FAST_SLEW
);
    import pin_drive_pkg::*;

    // ----------------------------------------------------------------
    // Drive-select registers
    // ----------------------------------------------------------------
    port_byte_s drive_ff;
    port_byte_s nxt_drive;

    always_comb begin
        nxt_drive = drive_ff;
        if (REG_WR) begin
            case (REG_ADDR)
                OFF_A_DRIVE: nxt_drive.a = REG_WDATA & MASK_A;   // [RL12]
                OFF_B_DRIVE: nxt_drive.b = REG_WDATA & MASK_B;   // [RL13]
                OFF_C_DRIVE: nxt_drive.c = REG_WDATA & MASK_C;   // [RL14] [RL8]
                OFF_D_DRIVE: nxt_drive.d = REG_WDATA & MASK_D;   // [RL15]
                // Readback offsets and unmapped offsets drop the write
                default:     nxt_drive = drive_ff;               // [RL21]
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            drive_ff <= '{DRIVE_RESET, DRIVE_RESET, DRIVE_RESET, DRIVE_RESET}; // [RL9]
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    // ----------------------------------------------------------------
    // Repeater and final enables
    // ----------------------------------------------------------------
    logic       window;
    logic       rpt_active;
    logic       rpt_drive;
    port_byte_s oe_final;
    port_byte_s data_final;
    port_byte_s out_ff;
    port_byte_s oe_ff;
    port_byte_s slew_ff;
    port_byte_s nxt_out;
    port_byte_s nxt_oe;
    port_byte_s nxt_slew;
    logic [7:0] rdin_ff;
    logic [7:0] nxt_rdin;
    logic       rdv_ff;
    logic       nxt_rdv;
    logic       rd_now;
    logic [1:0] rd_pipe_ff;
    logic [1:0] nxt_rd_pipe;
    logic [7:0] pin_s1_ff;
    logic [7:0] pin_s2_ff;
    logic [7:0] nxt_pin_s1;
    logic [7:0] nxt_pin_s2;

    // Decode qualification by the program-store strobe is the configurer's job
    assign window     = PERIPH_SELECT_ZERO | PERIPH_SELECT_ONE;                 // [RL2] [RL3]
    // Whole port switches together; enable bit gates it
    assign rpt_active = REPEATER_MODE_SEL & MEMORY_MAPPING_CONTROL[REPEAT_BIT]; // [RL5] [RL4]
    // Host write drives the pins outward; host read turns them to inputs
    assign rpt_drive  = rpt_active & window & !HOST_WR_N;                       // [RL1] [RL6]

    function automatic logic [7:0] apply_od(input logic [7:0] oe, input logic [7:0] dat,
                                            input logic [7:0] od);
        // Open-drain pins only drive while the data is low
        apply_od = oe & ~(od & dat);
    endfunction : apply_od

    always_comb begin
        oe_final.a = rpt_active ? {8{rpt_drive}}                                // [RL7] [RL16]
                                : (ARRAY_OE.a | DIRECTION.a);                   // [RL20]
        oe_final.b = (ARRAY_OE.b | DIRECTION.b) & MASK_B;                       // [RL20]
        oe_final.c = (ARRAY_OE.c | DIRECTION.c) & MASK_C;                       // [RL8]
        oe_final.d = (ARRAY_OE.d | DIRECTION.d) & MASK_D;
        data_final   = PIN_DATA;
        data_final.a = rpt_active ? HOST_DATA_OUT : PIN_DATA.a;                 // [RL1]
        nxt_out      = data_final;
        nxt_oe.a   = apply_od(oe_final.a, data_final.a, drive_ff.a & OD_A);     // [RL10]
        nxt_oe.b   = apply_od(oe_final.b, data_final.b, drive_ff.b & OD_B);     // [RL10]
        nxt_oe.c   = apply_od(oe_final.c, data_final.c, drive_ff.c & OD_C);     // [RL10]
        nxt_oe.d   = apply_od(oe_final.d, data_final.d, drive_ff.d & OD_D);
        nxt_slew.a = drive_ff.a & ~OD_A;                                        // [RL11]
        nxt_slew.b = drive_ff.b & ~OD_B;                                        // [RL11]
        nxt_slew.c = drive_ff.c & ~OD_C & MASK_C;
        nxt_slew.d = drive_ff.d & ~OD_D;                                        // [RL11]
        // Pin levels are asynchronous: only the second flop feeds logic, and the
        // read qualifier is delayed to meet the data that stood on the pins then
        nxt_pin_s1  = PIN_IN.a;
        nxt_pin_s2  = pin_s1_ff;
        rd_now      = rpt_active & window & !HOST_RD_N;                         // [RL1]
        nxt_rd_pipe = {rd_pipe_ff[0], rd_now};
        nxt_rdv     = rd_pipe_ff[1];
        nxt_rdin    = rd_pipe_ff[1] ? pin_s2_ff : rdin_ff;
    end

    // Registered so pins change one clean edge after their causes
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_ff  <= '0;
            oe_ff   <= '0;
            slew_ff <= '0;
            rdin_ff <= 8'h00;
            rdv_ff  <= 1'b0;
            rd_pipe_ff <= 2'b00;
            pin_s1_ff  <= 8'h00;
            pin_s2_ff  <= 8'h00;
        end else begin
            out_ff  <= nxt_out;
            oe_ff   <= nxt_oe;
            slew_ff <= nxt_slew;
            rdin_ff <= nxt_rdin;
            rdv_ff  <= nxt_rdv;
            rd_pipe_ff <= nxt_rd_pipe;
            pin_s1_ff  <= nxt_pin_s1;
            pin_s2_ff  <= nxt_pin_s2;
        end
    end

    assign PIN_OUT            = out_ff;
    assign PIN_OE             = oe_ff;
    assign PIN_FAST_SLEW      = slew_ff;
    assign HOST_DATA_IN       = rdin_ff;
    assign HOST_DATA_IN_VALID = rdv_ff;

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    // Readback shows the enable the output stage holds this cycle
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = rdata_ff;
        if (REG_RD) begin
            case (REG_ADDR)
                OFF_A_DRIVE:  nxt_rdata = drive_ff.a;
                OFF_B_DRIVE:  nxt_rdata = drive_ff.b;
                OFF_C_DRIVE:  nxt_rdata = drive_ff.c & MASK_C;      // [RL21]
                OFF_D_DRIVE:  nxt_rdata = drive_ff.d & MASK_D;      // [RL21]
                OFF_A_OESTAT: nxt_rdata = oe_ff.a;                  // [RL17] [RL18]
                OFF_B_OESTAT: nxt_rdata = oe_ff.b;                  // [RL18]
                OFF_C_OESTAT: nxt_rdata = oe_ff.c & MASK_C;         // [RL19]
                OFF_D_OESTAT: nxt_rdata = oe_ff.d & MASK_D;         // [RL19]
                default:      nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA = rdata_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_host_write;
        rpt_active && window && !HOST_WR_N;
    endsequence

    sequence s_host_read;
        rpt_active && window && !HOST_RD_N;
    endsequence

    // Read data trails the strobe by the two synchroniser flops and the capture
    sequence s_read_answer;
        ##3 (HOST_DATA_IN_VALID && (HOST_DATA_IN == $past(PIN_IN.a, 3)));
    endsequence

    property p_rpt_drive;
        @(posedge CLK) disable iff (!RESET_N)
        s_host_write and ((drive_ff.a & OD_A & HOST_DATA_OUT) == 8'h00) |=>
            (PIN_OE.a == 8'hFF) && (PIN_OUT.a == $past(HOST_DATA_OUT));
    endproperty
    a_rpt_drive: assert property (p_rpt_drive) else $error("repeater not driving"); // [RL1]

    property p_rpt_read;
        @(posedge CLK) disable iff (!RESET_N)
        rpt_active && window && HOST_WR_N |=> PIN_OE.a == 8'h00;
    endproperty
    a_rpt_read: assert property (p_rpt_read) else $error("repeater drives outside write"); // [RL6]

    property p_window_or;
        @(posedge CLK) disable iff (!RESET_N)
        rpt_active && !HOST_RD_N && (PERIPH_SELECT_ZERO ^ PERIPH_SELECT_ONE)
            |-> s_read_answer;
    endproperty
    a_window_or: assert property (p_window_or) else $error("single select missed"); // [RL2]

    property p_need_enable;
        @(posedge CLK) disable iff (!RESET_N)
        !MEMORY_MAPPING_CONTROL[REPEAT_BIT] |-> ##3 !HOST_DATA_IN_VALID;
    endproperty
    a_need_enable: assert property (p_need_enable) else $error("repeater without enable"); // [RL4]

    property p_whole_port;
        @(posedge CLK) disable iff (!RESET_N)
        rpt_active && (DIRECTION.a != 8'h00) && !(window && !HOST_WR_N) |=> PIN_OE.a == 8'h00;
    endproperty
    a_whole_port: assert property (p_whole_port) else $error("port A leaked"); // [RL7]

    property p_scan_pins;
        @(posedge CLK) disable iff (!RESET_N)
        (PIN_OE.c & ~MASK_C) == 8'h00 && (drive_ff.c & ~MASK_C) == 8'h00;
    endproperty
    a_scan_pins: assert property (p_scan_pins) else $error("scan pin enabled"); // [RL8]

    property p_od_release;
        @(posedge CLK) disable iff (!RESET_N)
        drive_ff.b[7] && PIN_DATA.b[7] |=> !PIN_OE.b[7];
    endproperty
    a_od_release: assert property (p_od_release) else $error("open drain drove high"); // [RL10]

    property p_slew;
        @(posedge CLK) disable iff (!RESET_N)
        1'b1 |=> PIN_FAST_SLEW.a == ($past(drive_ff.a) & 8'h0F);
    endproperty
    a_slew: assert property (p_slew) else $error("slew mismatch"); // [RL11]

    property p_oe_or;
        @(posedge CLK) disable iff (!RESET_N)
        drive_ff.b == 8'h00 |=> PIN_OE.b == $past(ARRAY_OE.b | DIRECTION.b);
    endproperty
    a_oe_or: assert property (p_oe_or) else $error("enable not OR"); // [RL20]

    property p_readback;
        @(posedge CLK) disable iff (!RESET_N)
        REG_RD && REG_ADDR == OFF_D_OESTAT |=> REG_RDATA == ($past(PIN_OE.d) & 8'h06);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong"); // [RL19]

    property p_read_data;
        @(posedge CLK) disable iff (!RESET_N)
        s_host_read |-> s_read_answer;
    endproperty
    a_read_data: assert property (p_read_data) else $error("repeater read lost"); // [RL1]

    property p_write_a;
        @(posedge CLK) disable iff (!RESET_N)
        REG_WR && REG_ADDR == OFF_A_DRIVE |=> drive_ff.a == $past(REG_WDATA);
    endproperty
    a_write_a: assert property (p_write_a) else $error("port A drive write lost"); // [RL12]

    property p_write_c;
        @(posedge CLK) disable iff (!RESET_N)
        REG_WR && REG_ADDR == OFF_C_DRIVE |=> drive_ff.c == ($past(REG_WDATA) & 8'h9C);
    endproperty
    a_write_c: assert property (p_write_c) else $error("port C drive write wrong"); // [RL14]

    property p_write_d;
        @(posedge CLK) disable iff (!RESET_N)
        REG_WR && REG_ADDR == OFF_D_DRIVE |=> drive_ff.d == ($past(REG_WDATA) & 8'h06);
    endproperty
    a_write_d: assert property (p_write_d) else $error("port D drive write wrong"); // [RL15]

    property p_oestat_ro;
        @(posedge CLK) disable iff (!RESET_N)
        REG_WR && (REG_ADDR == OFF_A_OESTAT || REG_ADDR == OFF_B_OESTAT ||
            REG_ADDR == OFF_C_OESTAT || REG_ADDR == OFF_D_OESTAT) |=> $stable(drive_ff);
    endproperty
    a_oestat_ro: assert property (p_oestat_ro) else $error("readback write landed"); // [RL21]

    property p_od_c;
        @(posedge CLK) disable iff (!RESET_N)
        drive_ff.c[2] && PIN_DATA.c[2] |=> !PIN_OE.c[2];
    endproperty
    a_od_c: assert property (p_od_c) else $error("port C open drain drove high"); // [RL10]

    property p_slew_b;
        @(posedge CLK) disable iff (!RESET_N)
        1'b1 |=> PIN_FAST_SLEW.b == ($past(drive_ff.b) & 8'h0F);
    endproperty
    a_slew_b: assert property (p_slew_b) else $error("port B slew mismatch"); // [RL13]

    property p_array_a;
        @(posedge CLK) disable iff (!RESET_N)
        !rpt_active && drive_ff.a == 8'h00 |=> PIN_OE.a == $past(ARRAY_OE.a | DIRECTION.a);
    endproperty
    a_array_a: assert property (p_array_a) else $error("port A enable sources wrong"); // [RL16]

endmodule : pin_drive

// ===== bench/periph_model.sv
/*
 * Parallel peripheral on the repeated port A data bus: keeps the last
 * byte written to it and hands it back on a selected read.
 * Assumes the bench resolves the wire from the pin drive's enables alone.
 */
`timescale 1ns/100ps
module periph_model (
    // Clock
    input  wire logic       clk,
    // Host strobes and decoded select
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic       sel,
    // Resolved bus and this side's drive
    input  wire logic [7:0] bus,
    output logic      [7:0] drv
);
    logic [7:0] mem_ff;
    logic [7:0] last_ff;
    initial mem_ff = 8'h3C;
    initial last_ff = 8'h00;
    // Latch every cycle of a selected write; the last one holds settled data
    always @(posedge clk) if (!wr_n && sel) mem_ff <= bus;
    // Released bus shows the inverse of its last value so stale data never matches
    assign drv = (!rd_n && sel) ? mem_ff : ~last_ff;
    always @(posedge clk) last_ff <= drv;
endmodule : periph_model

// ===== bench/tb_top.sv
/*
 * Self-checking bench for pin_drive: drive registers, output enables,
 * enable readback and the port A repeater against a bench model.
 * Assumes periph_model on port A; inputs change at the falling edge.
 */
`timescale 1ns/100ps
module tb_top;
    import pin_drive_pkg::*;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic       clk, reset_n, reg_wr, reg_rd, rpt_sel, psel0, periph_select_one, rd_n, wr_n, hdi_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, mmc, hdo, hdi, pdrv;
    logic [7:0] dsel[4];
    logic [7:0] wr_q[$];
    logic [23:0] pin_in_bcd;
    port_byte_s arr_oe, dir, pdat, pin_in, pin_out, pin_oe, pin_fast;
    int         fails = 0;
    int         samples_checked = 0;
    localparam logic [7:0] DOFF[4] = '{OFF_A_DRIVE, OFF_B_DRIVE, OFF_C_DRIVE, OFF_D_DRIVE};
    localparam logic [7:0] OOFF[4] = '{OFF_A_OESTAT, OFF_B_OESTAT, OFF_C_OESTAT, OFF_D_OESTAT};
    localparam logic [7:0] MSK[4]  = '{MASK_A, MASK_B, MASK_C, MASK_D};
    localparam logic [7:0] ODC[4]  = '{OD_A, OD_B, OD_C, OD_D};

    pin_drive pin_drive_inst (.CLK(clk), .RESET_N(reset_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .MEMORY_MAPPING_CONTROL(mmc), .REPEATER_MODE_SEL(rpt_sel),
        .PERIPH_SELECT_ZERO(psel0), .PERIPH_SELECT_ONE(periph_select_one), .HOST_RD_N(rd_n),
        .HOST_WR_N(wr_n), .HOST_DATA_OUT(hdo), .HOST_DATA_IN(hdi),
        .HOST_DATA_IN_VALID(hdi_valid), .ARRAY_OE(arr_oe), .DIRECTION(dir), .PIN_DATA(pdat),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_FAST_SLEW(pin_fast));
    periph_model periph_model_inst (.clk(clk), .wr_n(wr_n), .rd_n(rd_n),
        .sel(psel0 | periph_select_one), .bus(pin_in.a), .drv(pdrv));
    // Port A wire: whoever enables drives, the peripheral fills the rest
    assign pin_in = {(pin_oe.a & pin_out.a) | (~pin_oe.a & pdrv), pin_in_bcd};

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] pb(input port_byte_s s, input int p);
        return s[8*(3-p) +: 8];
    endfunction : pb
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic reg_acc(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        @(negedge clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = addr;
        reg_wdata = wd;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        @(negedge clk);
    endtask : reg_acc
    task automatic chk_pins(input logic rpt);
        logic [7:0] oe;
        repeat (2) @(negedge clk);
        for (int p = 0; p < 4; p++) begin
            oe = (pb(arr_oe, p) | pb(dir, p)) & MSK[p] & ~(dsel[p] & ODC[p] & pb(pdat, p));
            if (p == 0 && rpt) oe = (!wr_n && (psel0 || periph_select_one)) ? 8'hFF : 8'h00;
            chk8("pin_oe", oe, pb(pin_oe, p));
            chk8("pin_out", ((p == 0 && rpt) ? hdo : pb(pdat, p)) & oe, pb(pin_out, p) & oe);
            chk8("fast_slew", dsel[p] & MSK[p] & ~ODC[p], pb(pin_fast, p));
            reg_acc(1'b0, OOFF[p], 8'h00);
            chk8("oe_state", oe, reg_rdata);
        end
    endtask : chk_pins
    task automatic results;
        $display("Comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, reg_wr, reg_rd, rpt_sel, psel0, periph_select_one, reg_addr, reg_wdata, mmc, hdo} = '0;
        {arr_oe, dir, pdat, pin_in_bcd} = '0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        void'($urandom(78));
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        for (int p = 0; p < 4; p++) begin
            reg_acc(1'b0, DOFF[p], 8'h00);
            chk8("drive_reset", DRIVE_RESET, reg_rdata);
        end
        reg_acc(1'b0, 8'h20, 8'h00);
        chk8("unmapped", 8'h00, reg_rdata);
        // Random drive types and sources; repeater chosen at random but never enabled
        repeat (12) begin
            for (int p = 0; p < 4; p++) begin
                reg_acc(1'b1, DOFF[p], 8'($urandom));
                dsel[p] = reg_wdata & MSK[p];
                reg_acc(1'b1, OOFF[p], 8'($urandom));
            end
            arr_oe = port_byte_s'($urandom);
            dir = port_byte_s'($urandom);
            pdat = port_byte_s'($urandom);
            pin_in_bcd = 24'($urandom);
            rpt_sel = 1'($urandom);
            mmc = 8'($urandom) & 8'h7F;
            chk_pins(1'b0);
            for (int p = 0; p < 4; p++) begin
                reg_acc(1'b0, DOFF[p], 8'h00);
                chk8("drive_rb", dsel[p], reg_rdata);
            end
        end
        // Repeater: every select combination, write out then read back
        reg_acc(1'b1, OFF_A_DRIVE, 8'h0F);
        dsel[0] = 8'h0F;
        rpt_sel = 1'b1;
        mmc = 8'h80;
        for (int s = 0; s < 4; s++) begin
            hdo = 8'($urandom);
            psel0 = s[0];
            periph_select_one = s[1];
            wr_n = 1'b0;
            if (s != 0) wr_q.push_back(hdo);
            chk_pins(1'b1);
            wr_n = 1'b1;
            @(negedge clk);
            rd_n = 1'b0;
            @(negedge clk);
            rd_n = 1'b1;
            chk8("rd_oe", 8'h00, pin_oe.a);
            // Pin levels pass two synchroniser flops before the host sees them
            repeat (2) @(negedge clk);
            chk8("rd_valid", {7'h00, s != 0}, {7'h00, hdi_valid});
            if (s != 0) chk8("host_in", wr_q.pop_front(), hdi);
            @(negedge clk);
            chk8("rd_pulse", 8'h00, {7'h00, hdi_valid});
        end
        results();
    end
endmodule : tb_top
